/* File: rtl/pcpg_pkg.sv */
// Purpose: shared constants and types of the panel control pulse generator
// Assumes: 32-bit AHB-Lite register bus, one clock
// Notes:   channel registers sit at a fixed stride, status word last
package pcpg_pkg;

   // channel count and counter widths
   localparam int NCH    = 9;
   localparam int LINE_W = 11;
   localparam int PIX_W  = 11;
   localparam int CTRL_W = 2;

   // control setting bits
   localparam int CTRL_POL_BIT = 0;
   localparam int CTRL_TOG_BIT = 1;

   // pixel count runs this many clocks ahead of first output data
   localparam logic [PIX_W-1:0] PIX_LEAD = 11'h006;

   // strap bits
   localparam int STRAP_W        = 5;
   localparam int STRAP_ONCE_BIT = 2;

   // register map, byte offsets inside the block
   localparam int                OFS_W      = 12;
   localparam logic [OFS_W-1:0]  CH_STRIDE  = 12'h020;
   localparam logic [2:0]        K_VSTART   = 3'h0;
   localparam logic [2:0]        K_VDUR     = 3'h1;
   localparam logic [2:0]        K_HSTART   = 3'h2;
   localparam logic [2:0]        K_HDUR     = 3'h3;
   localparam logic [2:0]        K_CTRL     = 3'h4;
   localparam int                CH_LSB     = 5;
   localparam int                K_LSB      = 2;
   localparam logic [OFS_W-1:0]  REG_STATUS = 12'h200;

   // status word fields
   localparam int STAT_PIX_LSB    = 0;
   localparam int STAT_LOADED_BIT = 11;
   localparam int STAT_LINE_LSB   = 16;
   localparam int STAT_STRAP_LSB  = 27;

   // AHB-Lite codes
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   // one channel's settings
   typedef struct packed {
      logic [LINE_W-1:0] vstart;
      logic [LINE_W-1:0] vdur;
      logic [PIX_W-1:0]  hstart;
      logic [PIX_W-1:0]  hdur;
      logic [CTRL_W-1:0] ctrl;
   } pcpg_chan_cfg_t;

   localparam pcpg_chan_cfg_t CFG_RST = '0;

endpackage

/* File: rtl/pcpg_channel.sv */
// Purpose: one programmable control output channel
// Assumes: line and pixel counts come from the top, already restarted
// Notes:   output lags the pixel match by two clocks
`timescale 1ns/100ps
module pcpg_channel
   import pcpg_pkg::*;
(
   // clock and reset
   input  wire logic           i_clk,
   input  wire logic           i_srst,
   // settings and counts
   input  wire pcpg_chan_cfg_t i_cfg,
   input  wire logic [LINE_W-1:0] i_line,
   input  wire logic [PIX_W-1:0]  i_pix,
   // output level
   output logic                o_level
);

   logic [LINE_W:0]  v_end;
   logic             v_en;
   logic             multi;
   logic             at_h;
   logic             start;
   logic             m_on;
   logic             m_off;
   logic             active;
   logic             active_d;
   logic [PIX_W-1:0] cnt;
   logic             tog;
   logic             rise;
   logic             next_tog;
   logic             tog_mode;
   logic             pol;

   assign tog_mode = i_cfg.ctrl[CTRL_TOG_BIT];
   assign pol      = i_cfg.ctrl[CTRL_POL_BIT];
   assign v_end    = {1'b0, i_cfg.vstart} + {1'b0, i_cfg.vdur};
   // zero duration means no vertical gating at all
   assign v_en  = (i_cfg.vdur == '0) ||
                  ({1'b0, i_line} >= {1'b0, i_cfg.vstart} &&
                   {1'b0, i_line} < v_end);
   assign multi = (i_cfg.vdur != '0) && (i_cfg.hdur == '0);
   assign at_h  = (i_pix == i_cfg.hstart);
   assign start = at_h && v_en && (i_cfg.hdur != '0);
   assign m_on  = multi && at_h && (i_line == i_cfg.vstart);
   assign m_off = multi && at_h && ({1'b0, i_line} == v_end);

   // a running pulse is never retriggered, so a duration longer than
   // a line skips the next line's start
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         active <= 1'b0;
         cnt    <= '0;
      end else if (multi) begin
         if (m_on) begin
            active <= 1'b1;
         end else if (m_off) begin
            active <= 1'b0;
         end
      end else if (!active) begin
         if (start) begin
            active <= 1'b1;
            cnt    <= i_cfg.hdur - PIX_W'(1);
         end
      end else if (cnt == '0) begin
         active <= 1'b0;
      end else begin
         cnt <= cnt - PIX_W'(1);
      end
   end

   assign rise     = active && !active_d;
   assign next_tog = tog ^ rise;

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         active_d <= 1'b0;
         tog      <= 1'b0;
         o_level  <= 1'b0;
      end else begin
         active_d <= active;
         tog      <= next_tog;
         o_level  <= (tog_mode ? next_tog : active) ^ pol;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   a_hstart_fire: assert property (!multi && !active && start |=>
      active && cnt == $past(i_cfg.hdur) - PIX_W'(1))
      else $error("pulse did not start at the horizontal start");
   a_vwin_block: assert property (!multi && !active && !v_en |=> !active)
      else $error("pulse started outside the vertical window");
   a_hdur_hold: assert property (!multi && active && cnt != '0 |=> active)
      else $error("pulse ended before its duration");
   a_hdur_end: assert property (!multi && active && cnt == '0 |=> !active)
      else $error("pulse outlived its duration");
   a_multi_span: assert property (m_off |=> !active)
      else $error("multi-line pulse did not end on its last line");
   a_pol_out: assert property (!tog_mode |=>
      o_level == ($past(active) ^ $past(pol)))
      else $error("output polarity wrong");
   a_toggle_flip: assert property (tog_mode && rise && $past(tog_mode)
      && $stable(pol) |=> o_level != $past(o_level))
      else $error("toggle output did not flip on a rising edge");

endmodule // pcpg_channel

/* File: rtl/pcpg_top.sv */
// Purpose: panel control pulse generator with AHB-Lite register access
// Assumes: frame and line start pulses come from the output timing, one
//          clock wide; frame start also counts as a line start
// Notes:   zero wait state slave, always OKAY
// Operation
// - Every control output is made by comparing line and pixel counts to settings.
// - A vertical start and duration pair gives each output's window in lines.
// - Vertical start is the first active line; duration counts the enabled lines.
// - Horizontal start is the pixel count at which the output goes active.
// - Horizontal duration is how many pixel counts the output stays active.
// - Horizontal pulses happen only on lines inside the vertical window; a zero vertical duration lets them happen on every line.
// - Strap two low reloads settings every frame; high loads them once.
// - Control bit zero inverts the output, constant levels included.
// - Control bit one makes the output toggle on each generated rising edge.
// - Pixel count starts six clocks before the line's first output data.
// - A horizontal duration of at least one line but under two lines pulses every other line.
`timescale 1ns/100ps
module pcpg_top
   import pcpg_pkg::*;
#(
   parameter int P_NCH = NCH
)(
   // clock and reset
   input  wire logic              I_CLK,
   input  wire logic              I_SRST,
   // AHB-Lite slave
   input  wire logic              I_HSEL,
   input  wire logic [31:0]       I_HADDR,
   input  wire logic [1:0]        I_HTRANS,
   input  wire logic              I_HWRITE,
   input  wire logic [2:0]        I_HSIZE,
   input  wire logic [31:0]       I_HWDATA,
   input  wire logic              I_HREADY,
   output logic                   O_HREADYOUT,
   output logic                   O_HRESP,
   output logic [31:0]            O_HRDATA,
   // output timing
   input  wire logic              I_FRAME_START,
   input  wire logic              I_LINE_START,
   // configuration straps
   input  wire logic [STRAP_W-1:0] I_TEST_STRAP,
   // panel controls
   output logic [P_NCH-1:0]       O_PROGRAMMABLE_CONTROL_OUTPUTS,
   output logic                   O_DATA_START,
   // serial memory reload request
   output logic                   O_RELOAD_REQ
);

   pcpg_chan_cfg_t    cfg [P_NCH];
   logic [LINE_W-1:0] line;
   logic [PIX_W-1:0]  pix;
   logic              loaded;
   logic              strap_once;

   // bus state
   logic              addr_ok;
   logic              wr_pend;
   logic [OFS_W-1:0]  wr_ofs;
   logic [OFS_W-1:0]  rd_ofs;
   logic [31:0]       next_rdata;
   logic [3:0]        wr_ch;
   logic [2:0]        wr_k;
   logic [3:0]        rd_ch;
   logic [2:0]        rd_k;

   assign strap_once = I_TEST_STRAP[STRAP_ONCE_BIT];

   // -------- line and pixel counters
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         line <= '0;
      end else if (I_FRAME_START) begin
         line <= '0;
      end else if (I_LINE_START && line != '1) begin
         line <= line + LINE_W'(1);
      end
   end

   // pixel count saturates so a stalled line never wraps into a start
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         pix <= '0;
      end else if (I_FRAME_START || I_LINE_START) begin
         pix <= '0;
      end else if (pix != '1) begin
         pix <= pix + PIX_W'(1);
      end
   end

   // marks where output data begins, PIX_LEAD counts into the line
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         O_DATA_START <= 1'b0;
      end else begin
         O_DATA_START <= (pix == PIX_LEAD);
      end
   end

   // -------- serial memory reload
   // the download engine itself lives elsewhere; this only asks for it
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         O_RELOAD_REQ <= 1'b0;
         loaded       <= 1'b0;
      end else begin
         O_RELOAD_REQ <= I_FRAME_START && (!strap_once || !loaded);
         if (I_FRAME_START) begin
            loaded <= 1'b1;
         end
      end
   end

   // -------- AHB-Lite slave
   assign O_HREADYOUT = 1'b1;
   assign O_HRESP     = HRESP_OKAY;
   assign addr_ok     = I_HSEL && I_HREADY && (I_HTRANS == HTRANS_NONSEQ);
   assign rd_ofs      = I_HADDR[OFS_W-1:0];
   assign rd_ch       = rd_ofs[CH_LSB +: 4];
   assign rd_k        = rd_ofs[K_LSB +: 3];
   assign wr_ch       = wr_ofs[CH_LSB +: 4];
   assign wr_k        = wr_ofs[K_LSB +: 3];

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         wr_pend <= 1'b0;
         wr_ofs  <= '0;
      end else begin
         wr_pend <= addr_ok && I_HWRITE;
         if (addr_ok) begin
            wr_ofs <= rd_ofs;
         end
      end
   end

   // read data is fetched in the address phase so it stands from a flop
   always_comb begin
      next_rdata = '0;
      if (rd_ofs == REG_STATUS) begin
         next_rdata[STAT_PIX_LSB +: PIX_W]     = pix;
         next_rdata[STAT_LOADED_BIT]           = loaded;
         next_rdata[STAT_LINE_LSB +: LINE_W]   = line;
         next_rdata[STAT_STRAP_LSB +: STRAP_W] = I_TEST_STRAP;
      end else if (rd_ofs < OFS_W'(P_NCH * CH_STRIDE) &&
                   rd_ofs[1:0] == 2'h0) begin
         if (rd_k == K_VSTART) begin
            next_rdata[LINE_W-1:0] = cfg[rd_ch].vstart;
         end else if (rd_k == K_VDUR) begin
            next_rdata[LINE_W-1:0] = cfg[rd_ch].vdur;
         end else if (rd_k == K_HSTART) begin
            next_rdata[PIX_W-1:0] = cfg[rd_ch].hstart;
         end else if (rd_k == K_HDUR) begin
            next_rdata[PIX_W-1:0] = cfg[rd_ch].hdur;
         end else if (rd_k == K_CTRL) begin
            next_rdata[CTRL_W-1:0] = cfg[rd_ch].ctrl;
         end
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         O_HRDATA <= '0;
      end else if (addr_ok && !I_HWRITE) begin
         O_HRDATA <= next_rdata;
      end
   end

   // -------- channel settings, written in the data phase
   always_ff @(posedge I_CLK) begin
      if (I_SRST) begin
         for (int i = 0; i < P_NCH; i++) begin
            cfg[i] <= CFG_RST;
         end
      end else if (wr_pend && wr_ofs < OFS_W'(P_NCH * CH_STRIDE) &&
                   wr_ofs[1:0] == 2'h0) begin
         if (wr_k == K_VSTART) begin
            cfg[wr_ch].vstart <= I_HWDATA[LINE_W-1:0];
         end else if (wr_k == K_VDUR) begin
            cfg[wr_ch].vdur <= I_HWDATA[LINE_W-1:0];
         end else if (wr_k == K_HSTART) begin
            cfg[wr_ch].hstart <= I_HWDATA[PIX_W-1:0];
         end else if (wr_k == K_HDUR) begin
            cfg[wr_ch].hdur <= I_HWDATA[PIX_W-1:0];
         end else if (wr_k == K_CTRL) begin
            cfg[wr_ch].ctrl <= I_HWDATA[CTRL_W-1:0];
         end
      end
   end

   // -------- output channels
   for (genvar g = 0; g < P_NCH; g++) begin : g_ch
      pcpg_channel u_ch (
         .i_clk   (I_CLK),
         .i_srst  (I_SRST),
         .i_cfg   (cfg[g]),
         .i_line  (line),
         .i_pix   (pix),
         .o_level (O_PROGRAMMABLE_CONTROL_OUTPUTS[g])
      );
   end

   // -------- checks
   sequence s_line_begin;
      I_LINE_START && !I_FRAME_START;
   endsequence

   sequence s_no_start;
      !I_LINE_START && !I_FRAME_START;
   endsequence

   // the data marker is a flop behind the pix == 6 compare, so seven quiet clocks
   sequence s_quiet_lead;
      s_no_start [*7];
   endsequence

   a_frame_restart: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_FRAME_START |=> line == '0 && pix == '0)
      else $error("counters did not restart at frame start");

   a_line_advance: assert property (@(posedge I_CLK) disable iff (I_SRST)
      s_line_begin and (line != '1) |=> pix == '0 && line == $past(line) + LINE_W'(1))
      else $error("line start did not advance the line count");

   a_data_lead: assert property (@(posedge I_CLK) disable iff (I_SRST)
      s_line_begin ##1 s_quiet_lead |=> O_DATA_START)
      else $error("data start not six counts into the line");

   a_reload_each: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_FRAME_START && !strap_once |=> O_RELOAD_REQ)
      else $error("no reload request at frame start");

   a_reload_once: assert property (@(posedge I_CLK) disable iff (I_SRST)
      loaded && strap_once |=> !O_RELOAD_REQ)
      else $error("reload repeated with once strap set");

   a_out_reset: assert property (@(posedge I_CLK)
      I_SRST |=> O_PROGRAMMABLE_CONTROL_OUTPUTS == '0 && !O_RELOAD_REQ)
      else $error("outputs not idle after reset");

   a_cfg_write: assert property (@(posedge I_CLK) disable iff (I_SRST)
      wr_pend && wr_ofs == (CH_STRIDE + OFS_W'({K_HSTART, 2'h0}))
      |=> cfg[1].hstart == $past(I_HWDATA[PIX_W-1:0]))
      else $error("horizontal start write lost");

   a_pix_step: assert property (@(posedge I_CLK) disable iff (I_SRST)
      !I_LINE_START && !I_FRAME_START && pix != '1
      |=> pix == $past(pix) + PIX_W'(1))
      else $error("pixel count did not advance");

   a_line_hold: assert property (@(posedge I_CLK) disable iff (I_SRST)
      !I_LINE_START && !I_FRAME_START
      |=> line == $past(line))
      else $error("line count moved without a line start");

   a_data_once: assert property (@(posedge I_CLK) disable iff (I_SRST)
      O_DATA_START
      |=> !O_DATA_START)
      else $error("data start wider than one clock");

   a_data_quiet: assert property (@(posedge I_CLK) disable iff (I_SRST)
      pix != PIX_LEAD
      |=> !O_DATA_START)
      else $error("data start away from the lead count");

   a_loaded_set: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_FRAME_START
      |=> loaded)
      else $error("loaded flag not set by a frame start");

   a_reload_first: assert property (@(posedge I_CLK) disable iff (I_SRST)
      I_FRAME_START && !loaded
      |=> O_RELOAD_REQ)
      else $error("first frame after reset did not ask for a reload");

   a_reload_quiet: assert property (@(posedge I_CLK) disable iff (I_SRST)
      !I_FRAME_START
      |=> !O_RELOAD_REQ)
      else $error("reload request without a frame start");

   a_rdata_hold: assert property (@(posedge I_CLK) disable iff (I_SRST)
      !(addr_ok && !I_HWRITE)
      |=> $stable(O_HRDATA))
      else $error("read data moved without a read");

   a_status_count: assert property (@(posedge I_CLK) disable iff (I_SRST)
      addr_ok && !I_HWRITE && rd_ofs == REG_STATUS
      |=> O_HRDATA[STAT_LINE_LSB +: LINE_W] == $past(line) &&
          O_HRDATA[STAT_PIX_LSB +: PIX_W] == $past(pix))
      else $error("status read did not return the counts");

   a_hstart_write: assert property (@(posedge I_CLK) disable iff (I_SRST)
      wr_pend && wr_ofs == OFS_W'({K_HSTART, 2'h0})
      |=> cfg[0].hstart == $past(I_HWDATA[PIX_W-1:0]))
      else $error("channel zero horizontal start write lost");

   a_vdur_write: assert property (@(posedge I_CLK) disable iff (I_SRST)
      wr_pend && wr_ofs == OFS_W'(2 * CH_STRIDE) + OFS_W'({K_VDUR, 2'h0})
      |=> cfg[2].vdur == $past(I_HWDATA[LINE_W-1:0]))
      else $error("channel two vertical duration write lost");

   a_cfg_reset: assert property (@(posedge I_CLK)
      I_SRST
      |=> cfg[0] == CFG_RST)
      else $error("settings not cleared by reset");

endmodule // pcpg_top

/* File: test/pcpg_panel_model.sv */
// Purpose: column and row driver control inputs fed by the panel controls
// Assumes: drivers sample on the output clock rising edge
// Notes:   drivers never answer back, so the model only counts edges, widths and reloads and notes positions
`timescale 1ns/100ps
module pcpg_panel_model
   import pcpg_pkg::*;
(
   // clock and counter clear
   input  wire logic           i_clk,
   input  wire logic           i_clr,
   // driver control inputs
   input  wire logic [NCH-1:0] i_ctl,
   input  wire logic           i_line_start,
   input  wire logic           i_data_start,
   input  wire logic           i_reload
);
   int             rise_cnt [NCH];
   int             high_cnt [NCH];
   int             rise_pos [NCH];
   int             ds_pos     = 0;
   int             reload_cnt = 0;
   int             pos        = 0;
   logic [NCH-1:0] prev       = '0;

   // pixel position of the line as the drivers see it
   always @(posedge i_clk) begin
      pos <= i_line_start ? 0 : pos + 1;
      prev <= i_ctl;
      if (i_data_start) ds_pos <= pos;
      if (i_reload) reload_cnt <= reload_cnt + 1;
      for (int i = 0; i < NCH; i++) begin
         if (i_ctl[i] && !prev[i]) begin
            rise_cnt[i] <= rise_cnt[i] + 1;
            rise_pos[i] <= pos;
         end
         if (i_ctl[i]) high_cnt[i] <= high_cnt[i] + 1;
         // clear wins over counting in the same edge
         if (i_clr) begin
            rise_cnt[i] <= 0;
            high_cnt[i] <= 0;
         end
      end
      if (i_clr) reload_cnt <= 0;
   end
endmodule // pcpg_panel_model

/* File: test/tb_panel_control_pulse_generator.sv */
// Purpose: self-checking bench of the panel control pulse generator
// Assumes: zero wait bus slave, lines of 20 clocks
// Notes:   toggle levels are compared before and after frames, not absolutely,
//          since channels may fire while settings are half written
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_panel_control_pulse_generator;
   import pcpg_pkg::*;
   logic           clk = 0, srst = 1, hwrite = 0, fs = 0, ls = 0, clr = 0;
   logic [1:0]     htrans = 2'h0;
   logic [31:0]    haddr = '0, hwdata = '0, r;
   logic [4:0]     strap = 5'h00; // straps 0 to 4 all low
   logic           hreadyout, hresp, ds, reload;
   logic [31:0]    hrdata;
   logic [NCH-1:0] outs;
   int             error_cnt = 0, check_count = 0;

   initial begin
      forever #2 clk = ~clk;
   end

   pcpg_top dut (.I_CLK(clk), .I_SRST(srst), .I_HSEL(1'b1), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
      .I_HREADY(hreadyout), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
      .O_HRDATA(hrdata), .I_FRAME_START(fs), .I_LINE_START(ls),
      .I_TEST_STRAP(strap), .O_PROGRAMMABLE_CONTROL_OUTPUTS(outs),
      .O_DATA_START(ds), .O_RELOAD_REQ(reload));

   pcpg_panel_model drv (.i_clk(clk), .i_clr(clr), .i_ctl(outs),
      .i_line_start(ls), .i_data_start(ds), .i_reload(reload));

   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // bounded wait for the slave, a hang ends the run
   task automatic wait_rdy();
      int n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         error_cnt++;
         end_sim();
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a, d);
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask

   task automatic cfg(int ch, logic [10:0] vs, vd, hs, hd, logic [1:0] c);
      logic [31:0] v [5];
      v = '{32'(vs), 32'(vd), 32'(hs), 32'(hd), 32'(c)};
      for (int k = 0; k < 5; k++) bus(1'b1, 32'(ch) * 32'h20 + 32'(k) * 32'h4, v[k]);
   endtask

   // counters cleared first, then n lines of len clocks and a settle tail
   task automatic lines(int n, int len);
      clr <= 1'b1;
      // two clears, so a level settling from the last write is not an edge
      repeat (2) @(posedge clk);
      clr <= 1'b0;
      for (int i = 0; i < n; i++) begin
         fs <= (i == 0);
         ls <= 1'b1;
         @(posedge clk);
         fs <= 1'b0;
         ls <= 1'b0;
         repeat (len - 1) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask

   task automatic t_regs();
      bus(1'b1, 32'h0AC, 32'hFFFFFFFF);
      bus(1'b0, 32'h0AC, 32'h0);
      `CHK("ch5 hdur", 32'h7FF, r)
      `CHK("hresp", HRESP_OKAY, hresp)
      bus(1'b0, 32'h1FC, 32'h0);
      `CHK("unmapped", 32'h0, r)
      bus(1'b0, 32'h200, 32'h0);
      `CHK("straps", 5'h00, r[31:27])
   endtask

   task automatic t_line();
      cfg(0, 11'h0, 11'h0, 11'h006, 11'h003, 2'h0);
      lines(2, 20);
      `CHK("ch0 rises", 2, drv.rise_cnt[0])
      `CHK("ch0 width", 6, drv.high_cnt[0])
      // start 6 meets the data marker; the output flop adds one clock
      `CHK("ch0 lead", 1, drv.rise_pos[0] - drv.ds_pos)
   endtask

   task automatic t_window();
      cfg(2, 11'h002, 11'h002, 11'h005, 11'h003, 2'h0);
      // multi-line pulse: line 1 pixel 5 up to line 3 pixel 5
      cfg(4, 11'h001, 11'h002, 11'h005, 11'h000, 2'h0);
      lines(5, 20);
      `CHK("ch2 rises", 2, drv.rise_cnt[2])
      `CHK("ch2 width", 6, drv.high_cnt[2])
      `CHK("ch4 rises", 1, drv.rise_cnt[4])
      `CHK("ch4 width", 40, drv.high_cnt[4])
   endtask

   task automatic t_long();
      cfg(6, 11'h0, 11'h0, 11'h005, 11'h019, 2'h0);
      lines(4, 20);
      `CHK("ch6 rises", 2, drv.rise_cnt[6])
   endtask

   task automatic t_pol();
      cfg(1, 11'h0, 11'h0, 11'h0, 11'h0, 2'h1);
      lines(1, 20);
      `CHK("ch1 level", 1'b1, outs[1])
      `CHK("ch1 rises", 0, drv.rise_cnt[1])
   endtask

   task automatic t_toggle();
      logic b;
      cfg(3, 11'h0, 11'h0, 11'h005, 11'h003, 2'h2);
      b = outs[3];
      lines(3, 20);
      `CHK("ch3 odd", ~b, outs[3])
      lines(2, 20);
      `CHK("ch3 even", ~b, outs[3])
   endtask

   task automatic t_reload();
      lines(1, 20);
      lines(1, 20);
      `CHK("reload every", 1, drv.reload_cnt)
      strap <= 5'h04;
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      lines(1, 20);
      `CHK("reload once a", 1, drv.reload_cnt)
      lines(1, 20);
      `CHK("reload once b", 0, drv.reload_cnt)
   endtask

   initial begin
      repeat (3) @(posedge clk);
      `CHK("reset outs", 9'h000, outs)
      srst <= 1'b0;
      t_regs();
      t_line();
      t_window();
      t_long();
      t_pol();
      t_toggle();
      t_reload();
      end_sim();
   end
endmodule // tb_panel_control_pulse_generator
